/* rtl/lct_handler.v */
// Legacy command telegram handler: parses request bytes, writes word
// range payload through a FIFO, and streams the reply header and data.
// Assumes all inputs come from logic on clk_i; word storage sits outside.
//
// Notes on behaviour
// - Telegrams are accepted only when addressed to object class 0x67.
// - All 16-bit fields travel low byte first, both directions.
// - Command 0x0f is decoded with word range, input and protected functions.
// - Reply echoes the requester vendor identifier.
// - Reply echoes the requester serial number.
// - Reply header is 11 bytes, 12 when status is 0xf0.
// - Reply command is the request command with bit 6 set.
// - Status is 0x00, 0x10 or 0xf0; extended byte only with 0xf0.
// - Write word range reply carries header and status only.
// - Read word range returns at most 244 data bytes.
`timescale 1ns/10ps
`default_nettype none
`include "lct_defs.vh"

// ----------------------------------------
// Word FIFO
// ----------------------------------------
module lct_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = `LCT_FIFO_DEPTH,
  parameter AW = `LCT_FIFO_AW
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Fill side
  input wire in_valid_i,
  input wire [WIDTH-1:0] in_data_i,
  output wire in_ready_o,
  // Drain side
  output wire out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  integer i;
  assign in_ready_o = (cnt_q != DEPTH);
  assign out_valid_o = (cnt_q != 0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) rd_q <= rd_q + 1'b1;
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
// ----------------------------------------
// Telegram handler
// ----------------------------------------
module lct_handler (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Request byte stream
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  input wire rx_last_i,
  input wire [7:0] rx_class_i,
  output wire rx_ready_o,
  // Reply byte stream
  output wire tx_valid_o,
  output wire [7:0] tx_data_o,
  output wire tx_last_o,
  input wire tx_ready_i,
  // Word write port {element index, word}
  output wire wr_valid_o,
  output wire [15:0] wr_index_o,
  output wire [15:0] wr_word_o,
  input wire wr_ready_i,
  // Word read port, answered in the same cycle
  output wire [15:0] rd_index_o,
  input wire [15:0] rd_word_i
);
  localparam [1:0] S_RX = 2'd0;
  localparam [1:0] S_DROP = 2'd1;
  localparam [1:0] S_TX = 2'd2;
  localparam [1:0] PH_HDR = 2'd0;
  localparam [1:0] PH_ADDR = 2'd1;
  localparam [1:0] PH_BODY = 2'd2;
  reg [1:0] state_q;
  reg [1:0] ph_q;
  reg [4:0] cnt_q;
  reg [7:0] hdr_q [0:15];
  reg [1:0] addr_n_q;
  reg odd_q;
  reg [7:0] lo_q;
  reg [15:0] wcnt_q;
  reg [15:0] size_q;
  reg fail_q;
  reg bad_cmd_q;
  reg [8:0] tx_idx_q;
  reg [8:0] tx_n_q;
  reg tx_valid_q;
  reg tx_last_q;
  reg [7:0] tx_data_q;
  reg [7:0] tx_byte;
  integer i;
  wire [7:0] cmd = hdr_q[7];
  wire [7:0] function_selector = hdr_q[11];
  wire [15:0] pkt_off = {hdr_q[13], hdr_q[12]};
  wire take = rx_valid_i && rx_ready_o;
  wire fifo_in_ready;
  wire is_wr = (function_selector == `LCT_FNC_WR_RANGE);
  wire is_rd = (function_selector == `LCT_FNC_RD_RANGE);
  wire wr_push = (state_q == S_RX) && (ph_q == PH_BODY) && is_wr && odd_q && !fail_q && !bad_cmd_q;
  wire ext = bad_cmd_q;
  wire [7:0] sts = bad_cmd_q ? `LCT_STS_EXT : (fail_q ? `LCT_STS_FAIL : `LCT_STS_OK);
  wire [8:0] data_pos = tx_idx_q - `LCT_REPLY_HDR_BYTES - {8'h00, ext};
  wire tx_load = (state_q == S_TX) && (!tx_valid_q || tx_ready_i);
  // Payload waits for FIFO room so no word is lost
  assign rx_ready_o = (state_q == S_DROP) || ((state_q == S_RX) && (!wr_push || fifo_in_ready));
  assign tx_valid_o = tx_valid_q;
  assign tx_data_o = tx_data_q;
  assign tx_last_o = tx_last_q;
  assign rd_index_o = pkt_off + {8'h00, data_pos[8:1]};
  lct_fifo #(
    .WIDTH(32),
    .DEPTH(`LCT_FIFO_DEPTH),
    .AW(`LCT_FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(take && wr_push),
    .in_data_i({pkt_off + wcnt_q, rx_data_i, lo_q}),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(wr_valid_o),
    .out_data_o({wr_index_o, wr_word_o}),
    .out_ready_i(wr_ready_i)
  );
  // ----------------------------------------
  // Reply byte selection
  // ----------------------------------------
  always @* begin
    case (tx_idx_q)
      9'd0: tx_byte = `LCT_HDR_LEN;
      9'd1: tx_byte = hdr_q[1];
      9'd2: tx_byte = hdr_q[2];
      9'd3: tx_byte = hdr_q[3];
      9'd4: tx_byte = hdr_q[4];
      9'd5: tx_byte = hdr_q[5];
      9'd6: tx_byte = hdr_q[6];
      9'd7: tx_byte = cmd | (8'h01 << `LCT_CMD_REPLY_BIT);
      9'd8: tx_byte = sts;
      9'd9: tx_byte = hdr_q[9];
      9'd10: tx_byte = hdr_q[10];
      default: begin
        if (ext && tx_idx_q == `LCT_REPLY_HDR_BYTES) begin
          tx_byte = `LCT_EXT_BAD_CMD;
        end else begin
          tx_byte = data_pos[0] ? rd_word_i[15:8] : rd_word_i[7:0];
        end
      end
    endcase
  end
  // ----------------------------------------
  // Request parsing and reply sequencing
  // ----------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= S_RX;
      ph_q <= PH_HDR;
      cnt_q <= 5'd0;
      addr_n_q <= 2'd0;
      odd_q <= 1'b0;
      lo_q <= 8'h00;
      wcnt_q <= 16'h0000;
      size_q <= 16'h0000;
      fail_q <= 1'b0;
      bad_cmd_q <= 1'b0;
      tx_idx_q <= 9'd0;
      tx_n_q <= 9'd0;
      tx_valid_q <= 1'b0;
      tx_last_q <= 1'b0;
      tx_data_q <= 8'h00;
      for (i = 0; i < 16; i = i + 1) begin
        hdr_q[i] <= 8'h00;
      end
    end else begin
      case (state_q)
        S_RX: begin
          if (take) begin
            if (ph_q == PH_HDR) begin
              hdr_q[cnt_q[3:0]] <= rx_data_i;
              cnt_q <= cnt_q + 5'd1;
              if (cnt_q == 5'd0) begin
                fail_q <= (rx_data_i != `LCT_HDR_LEN);
                bad_cmd_q <= 1'b0;
                odd_q <= 1'b0;
                wcnt_q <= 16'h0000;
                addr_n_q <= 2'd0;
              end
              if (cnt_q == 5'd7 && rx_data_i != `LCT_CMD_LEGACY) bad_cmd_q <= 1'b1;
              if (cnt_q == 5'd11) begin
                case (rx_data_i)
                  `LCT_FNC_WR_RANGE, `LCT_FNC_RD_RANGE: ;
                  // Decoded but served by another block: refused without touching data
                  `LCT_FNC_WR_INPUT, `LCT_FNC_RD_INPUT, `LCT_FNC_RD_PROT2,
                  `LCT_FNC_RD_PROT3, `LCT_FNC_WR_PROT2, `LCT_FNC_WR_PROT3: fail_q <= 1'b1;
                  default: bad_cmd_q <= 1'b1;
                endcase
              end
              if (cnt_q == `LCT_CNT_BYTES - 5'd1) ph_q <= PH_ADDR;
            end else if (ph_q == PH_ADDR) begin
              // Address is text closed by a zero byte
              if (rx_data_i == 8'h00) begin
                ph_q <= PH_BODY;
                if (addr_n_q < `LCT_MIN_ADDR_BYTES) fail_q <= 1'b1;
              end else if (addr_n_q != 2'd3) begin
                addr_n_q <= addr_n_q + 2'd1;
              end
            end else begin
              odd_q <= !odd_q;
              if (!odd_q) begin
                lo_q <= rx_data_i;
              end else begin
                wcnt_q <= wcnt_q + 16'h0001;
                if (is_rd && wcnt_q == 16'h0000) size_q <= {rx_data_i, lo_q};
              end
            end
            if (rx_last_i) begin
              state_q <= S_TX;
              tx_idx_q <= 9'd0;
            end
          end
        end
        S_DROP: begin
          if (take && rx_last_i) state_q <= S_RX;
        end
        S_TX: begin
          if (tx_load) begin
            if (tx_idx_q == 9'd0 && !tx_valid_q) begin
              // Cut header, odd body or oversize read: status settles long before its byte leaves
              fail_q <= fail_q | (ph_q != PH_BODY) | odd_q | (is_rd && (size_q > `LCT_MAX_RD_WORDS));
              // Write replies and failed reads carry no data; good read replies carry size words
              tx_n_q <= `LCT_REPLY_HDR_BYTES + {8'h00, ext};
              if (is_rd && !fail_q && !bad_cmd_q && ph_q == PH_BODY && !odd_q &&
                  size_q <= `LCT_MAX_RD_WORDS) begin
                tx_n_q <= `LCT_REPLY_HDR_BYTES + {size_q[7:0], 1'b0};
              end
            end
            if (tx_idx_q == 9'd0 && !tx_valid_q || tx_idx_q < tx_n_q) begin
              tx_data_q <= tx_byte;
              tx_valid_q <= 1'b1;
              tx_idx_q <= tx_idx_q + 9'd1;
              tx_last_q <= (tx_idx_q != 9'd0 || tx_valid_q) && (tx_idx_q + 9'd1 == tx_n_q);
            end else begin
              tx_valid_q <= 1'b0;
              tx_last_q <= 1'b0;
              state_q <= S_RX;
              ph_q <= PH_HDR;
              cnt_q <= 5'd0;
            end
          end
        end
        default: state_q <= S_RX;
      endcase
      // Foreign class: swallow the telegram without a reply
      if (state_q == S_RX && ph_q == PH_HDR && cnt_q == 5'd0 && take &&
          rx_class_i != `LCT_CLASS_ID) begin
        cnt_q <= 5'd0;
        state_q <= rx_last_i ? S_RX : S_DROP;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/lct_defs.vh */
// Constants for the legacy command telegram handler.
// Assumes byte-wide streams and 16-bit fields sent low byte first.
`ifndef LCT_DEFS_VH
`define LCT_DEFS_VH

// ----------------------------------------
// Telegram codes
// ----------------------------------------
`define LCT_CLASS_ID 8'h67
`define LCT_CMD_LEGACY 8'h0f
`define LCT_CMD_REPLY_BIT 3'd6
`define LCT_HDR_LEN 8'h07
`define LCT_FNC_WR_RANGE 8'h00
`define LCT_FNC_RD_RANGE 8'h01
`define LCT_FNC_WR_INPUT 8'h67
`define LCT_FNC_RD_INPUT 8'h68
`define LCT_FNC_RD_PROT2 8'ha1
`define LCT_FNC_RD_PROT3 8'ha2
`define LCT_FNC_WR_PROT2 8'ha9
`define LCT_FNC_WR_PROT3 8'haa

// ----------------------------------------
// Reply status
// ----------------------------------------
`define LCT_STS_OK 8'h00
`define LCT_STS_FAIL 8'h10
`define LCT_STS_EXT 8'hf0
`define LCT_EXT_BAD_CMD 8'h06

// ----------------------------------------
// Layout and limits
// ----------------------------------------
`define LCT_REQ_HDR_BYTES 5'd12
`define LCT_CNT_BYTES 5'd16
`define LCT_REPLY_HDR_BYTES 9'd11
`define LCT_MIN_ADDR_BYTES 2'd2
`define LCT_MAX_RD_WORDS 16'd122
`define LCT_FIFO_DEPTH 8
`define LCT_FIFO_AW 3

`endif

/* dv/lct_handler_asserts.sv */
// Checker for the telegram handler reply and word streams.
// Assumes it is bound to lct_handler, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module lct_handler_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Streams
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic wr_valid_o,
  input wire logic [15:0] wr_word_o,
  input wire logic wr_ready_i
);
  // ---
  // Reply byte position and status seen
  // ---
  logic [8:0] pos_q;
  logic [7:0] sts_q;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_q <= 9'h000;
      sts_q <= 8'h00;
    end else if (tx_valid_o && tx_ready_i) begin
      pos_q <= tx_last_o ? 9'h000 : pos_q + 9'h001;
      if (pos_q == 9'h008) sts_q <= tx_data_o;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("reply byte changed while stalled");
  wr_hold_a: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_word_o))
    else $error("word changed while stalled");
  reply_start_a: assert property ($rose(tx_valid_o) |-> $past(rx_valid_i && rx_ready_o && rx_last_i, 2))
    else $error("reply start not two cycles after last byte");
  rx_quiet_a: assert property (tx_valid_o |-> !rx_ready_o)
    else $error("request taken during reply");
  hdr_len_a: assert property (tx_valid_o && pos_q == 9'h000 |-> tx_data_o == 8'h07)
    else $error("reply length byte wrong");
  cmd_bit_a: assert property (tx_valid_o && pos_q == 9'h007 |-> tx_data_o[6])
    else $error("reply command bit 6 clear");
  sts_code_a: assert property (tx_valid_o && pos_q == 9'h008 |-> tx_data_o inside {8'h00, 8'h10, 8'hf0})
    else $error("reply status code out of set");
  short_hdr_a: assert property (tx_valid_o && tx_last_o |-> pos_q >= 9'h00a && (pos_q != 9'h00a || sts_q != 8'hf0))
    else $error("reply header too short");
  ext_end_a: assert property (tx_valid_o && pos_q == 9'h00b && sts_q == 8'hf0 |-> tx_last_o)
    else $error("extended status reply not ended");
  data_cap_a: assert property (tx_valid_o |-> pos_q <= 9'h0fe)
    else $error("reply longer than allowed");
endmodule
bind lct_handler lct_handler_asserts u_chk (.clk_i, .rst_i, .rx_valid_i, .rx_last_i, .rx_ready_o, .tx_valid_o,
  .tx_data_o, .tx_last_o, .tx_ready_i, .wr_valid_o, .wr_word_o, .wr_ready_i);
`default_nettype wire

/* dv/lct_plc_model.sv */
// Requester model: sends command telegrams, collects reply bytes.
// Assumes the handler's byte streams on clk_i; reply sink stalls 1 in 4.
`timescale 1ns/10ps
`default_nettype none
module lct_plc_model (
  // Clock
  input wire logic clk_i,
  // Request stream
  output logic req_valid_o,
  output logic [7:0] req_data_o,
  output logic req_last_o,
  input wire logic req_ready_i,
  // Reply stream
  input wire logic rep_valid_i,
  input wire logic [7:0] rep_data_i,
  output logic rep_ready_o
);
  logic [7:0] req_q[$];
  logic [7:0] rep_q[$];
  logic [1:0] stall_q;
  initial begin
    req_valid_o = 1'b0;
    req_data_o = 8'h00;
    req_last_o = 1'b0;
    rep_ready_o = 1'b0;
    stall_q = 2'b00;
  end
  always @(negedge clk_i) begin
    stall_q <= stall_q + 2'b01;
    rep_ready_o <= (stall_q != 2'b11);
  end
  always @(posedge clk_i) begin
    if (rep_valid_i && rep_ready_o) rep_q.push_back(rep_data_i);
  end
  // Mode 1/3/5 read sizes 2/123/122, 2 odd body, 4 short address
  task automatic request(input logic [7:0] cmd, input logic [7:0] function_selector, input logic [15:0] tag, input int mode);
    req_q = {8'h07, 8'h34, 8'h12, 8'h78, 8'h56, 8'h34, 8'h12, cmd, 8'h00, tag[7:0], tag[15:8], function_selector};
    req_q = {req_q, 8'h05, 8'h00, 8'h02, 8'h00, 8'h4e};
    if (mode != 4) req_q.push_back(8'h37);
    req_q.push_back(8'h00);
    case (mode)
      1: req_q = {req_q, 8'h02, 8'h00};
      2: req_q.push_back(8'hcd);
      3: req_q = {req_q, 8'h7b, 8'h00};
      5: req_q = {req_q, 8'h7a, 8'h00};
      default: req_q = {req_q, 8'hcd, 8'hab, 8'h34, 8'h12};
    endcase
    foreach (req_q[i]) begin
      @(negedge clk_i);
      req_valid_o = 1'b1;
      req_data_o = req_q[i];
      req_last_o = (i == req_q.size() - 1);
      do @(posedge clk_i); while (!req_ready_i);
    end
    @(negedge clk_i);
    req_valid_o = 1'b0;
    req_last_o = 1'b0;
    // Released data line must not look like the last byte
    req_data_o = ~req_data_o;
  endtask
endmodule
`default_nettype wire

/* dv/lct_handler_tb.sv */
// Self-checking bench for lct_handler: table of telegrams, then reset abort.
// Assumes lct_plc_model as requester and a stalling word store here.
`timescale 1ns/10ps
`default_nettype none
module lct_handler_tb;
  typedef struct {logic [7:0] cls; logic [7:0] cmd; logic [7:0] function_selector; int mode; logic [7:0] sts;} lct_row_t;
  logic clk_i, rst_i, rx_valid_i, rx_last_i, rx_ready_o, tx_valid_o, tx_last_o, tx_ready_i, wr_valid_o, wr_ready_i;
  logic [7:0] rx_data_i, rx_class_i, tx_data_o;
  logic [15:0] wr_index_o, wr_word_o, rd_index_o, rd_word_i;
  logic [31:0] wr_q[$];
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  // Status 8'hff marks a telegram that must get no reply
  lct_row_t rows[15] = '{'{8'h67, 8'h0f, 8'h00, 0, 8'h00}, '{8'h67, 8'h0f, 8'h01, 1, 8'h00},
    '{8'h67, 8'h0f, 8'h01, 5, 8'h00}, '{8'h67, 8'h0f, 8'h67, 0, 8'h10}, '{8'h67, 8'h0f, 8'h68, 0, 8'h10},
    '{8'h67, 8'h0f, 8'ha1, 0, 8'h10}, '{8'h67, 8'h0f, 8'ha2, 0, 8'h10}, '{8'h67, 8'h0f, 8'ha9, 0, 8'h10},
    '{8'h67, 8'h0f, 8'haa, 0, 8'h10}, '{8'h67, 8'h0e, 8'h00, 0, 8'hf0}, '{8'h67, 8'h0f, 8'h55, 0, 8'hf0},
    '{8'h67, 8'h0f, 8'h00, 2, 8'h10}, '{8'h67, 8'h0f, 8'h01, 3, 8'h10}, '{8'h67, 8'h0f, 8'h00, 4, 8'h10},
    '{8'h66, 8'h0f, 8'h00, 0, 8'hff}};
  lct_handler u_dut (.clk_i, .rst_i, .rx_valid_i, .rx_data_i, .rx_last_i, .rx_class_i, .rx_ready_o, .tx_valid_o,
    .tx_data_o, .tx_last_o, .tx_ready_i, .wr_valid_o, .wr_index_o, .wr_word_o, .wr_ready_i, .rd_index_o, .rd_word_i);
  lct_plc_model u_plc (.clk_i, .req_valid_o(rx_valid_i), .req_data_o(rx_data_i), .req_last_o(rx_last_i),
    .req_ready_i(rx_ready_o), .rep_valid_i(tx_valid_o), .rep_data_i(tx_data_o), .rep_ready_o(tx_ready_i));
  assign rd_word_i = rd_index_o ^ 16'h5a5a;
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(negedge clk_i) wr_ready_i <= ~wr_ready_i;
  always @(posedge clk_i) begin
    if (wr_valid_o && wr_ready_i) wr_q.push_back({wr_index_o, wr_word_o});
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic run_row(input lct_row_t r, input logic [15:0] tag);
    int n;
    logic [15:0] w;
    wr_q = {};
    u_plc.rep_q = {};
    @(negedge clk_i);
    rx_class_i = r.cls;
    exp_q = {8'h07, 8'h34, 8'h12, 8'h78, 8'h56, 8'h34, 8'h12, r.cmd | 8'h40, r.sts, tag[7:0], tag[15:8]};
    if (r.sts == 8'hf0) exp_q.push_back(8'h06);
    if (r.sts == 8'h00 && r.mode != 0) begin
      // Word k comes from the store at packet offset 5 plus k, low byte first
      for (n = 0; n < (r.mode == 1 ? 2 : 122); n++) begin
        w = (16'h0005 + 16'(n)) ^ 16'h5a5a;
        exp_q = {exp_q, w[7:0], w[15:8]};
      end
    end
    if (r.sts == 8'hff) exp_q = {};
    u_plc.request(r.cmd, r.function_selector, tag, r.mode);
    n = 0;
    while (u_plc.rep_q.size() < exp_q.size() && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    repeat (20) @(negedge clk_i);
    check("reply length", 16'(u_plc.rep_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) if (i < u_plc.rep_q.size()) check("reply byte", {8'h00, u_plc.rep_q[i]}, {8'h00, exp_q[i]});
    check("word count", 16'(wr_q.size()), (r.sts == 8'h00 && r.mode == 0) ? 16'h0002 : 16'h0000);
    if (r.sts == 8'h00 && r.mode == 0) begin
      foreach (wr_q[k]) check("word", wr_q[k][15:0], k ? 16'h1234 : 16'habcd);
      foreach (wr_q[k]) check("word index", wr_q[k][31:16], 16'h0005 + 16'(k));
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    rx_class_i = 8'h67;
    wr_ready_i = 1'b0;
    repeat (8) @(negedge clk_i);
    check("idle in reset", {13'h0000, rx_ready_o, tx_valid_o, wr_valid_o}, 16'h0004);
    rst_i = 1'b0;
    foreach (rows[i]) run_row(rows[i], 16'h0001 + 16'(i) * 16'h1111);
    // Reset in mid-reply must drop the reply, then a clean run follows
    // The last table row leaves a foreign class behind, which would swallow this telegram
    rx_class_i = 8'h67;
    u_plc.request(8'h0f, 8'h00, 16'h0a0a, 0);
    wait (tx_valid_o);
    @(negedge clk_i);
    rst_i = 1'b1;
    @(negedge clk_i);
    check("abort idle", {13'h0000, rx_ready_o, tx_valid_o, wr_valid_o}, 16'h0004);
    rst_i = 1'b0;
    run_row(rows[0], 16'hffff);
    stop_test();
  end
endmodule
`default_nettype wire
